// ==== rtl/asrc_pkg.sv ====
/*
 Package for the asynchronous static RAM host controller: pin timing
 constants, state enumeration and carrier structs.
 Assumes a single 20 MHz clock and an attached 256K x 16 static RAM.
*/
// Function
// - Write only while select and strobe low
// - Data valid 6 ns before end
// - Strobe-ended write spans turn-off plus set-up
// - Address held 7 ns before end
// - Address valid before write starts
// - Byte enables low 7 ns before end
// - Write strobe high during reads
// - Wait 100 us after power-up
// - Deselect and hold high in retention
package asrc_pkg;

   // ------------------------------------------------------------
   // Widths and timing
   // ------------------------------------------------------------
   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_PS = 50000;
   localparam int T_AA_PS = 10000;
   localparam int T_SD_PS = 6000;
   localparam int T_HZWE_PS = 5000;
   localparam int T_PWE_PS = 7000;
   localparam int T_WC_PS = 10000;
   localparam int T_POWER_US = 100;
   // Least times round up, never below one cycle.
   localparam int RD_CYC =
      (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   localparam int WR_CYC =
      (T_HZWE_PS + T_SD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int PWE_CYC = (T_PWE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int GAP_CYC = (T_WC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int POWER_CYC =
      (T_POWER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 12;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_POWER, ST_IDLE, ST_SETUP, ST_WRITE, ST_READ, ST_GAP, ST_RETAIN
   } asrc_state_type;

   typedef struct packed {
      logic              write;
      logic [1:0]        lane_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asrc_req_type;

   typedef struct packed {
      logic              sel_n;
      logic              oe_n;
      logic              we_n;
      logic              low_byte_lane_enable_n;
      logic              high_byte_lane_enable_n;
      logic [ADDR_W-1:0] addr;
   } asrc_pins_type;

endpackage : asrc_pkg

// ==== rtl/asrc_timer.sv ====
/*
 Down counter for the controller's phase lengths.
 Assumes load and count come from logic on the same clock.
*/
module asrc_timer (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Control
   input  wire logic                     load,
   input  wire logic [asrc_pkg::CNT_W-1:0] value,
   // Status
   output logic                          done
);
   logic [asrc_pkg::CNT_W-1:0] cnt_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (load) begin
         cnt_r <= value;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // Done must not look at load, since the sequencer loads on done.
   assign done = (cnt_r == '0);
endmodule : asrc_timer

// ==== rtl/asrc_ctrl.sv ====
/*
 Host controller for an asynchronous 256K x 16 static RAM with byte lanes.
 Assumes the user port is on REF_CLK and the RAM pins connect directly.
 The data bus is split into input, output and an active-low output enable.
*/
module asrc_ctrl (
   // Clock and reset
   input  wire logic                        REF_CLK,
   input  wire logic                        RSTN,
   // User request
   input  wire logic                        REQ_VALID,
   output logic                             REQ_READY,
   input  wire asrc_pkg::asrc_req_type      REQ,
   output logic                             RD_VALID,
   output logic [asrc_pkg::DATA_W-1:0]      RD_DATA,
   input  wire logic                        RETAIN,
   output logic                             RETAINED,
   // Memory pins
   output asrc_pkg::asrc_pins_type          MEM,
   input  wire logic [asrc_pkg::DATA_W-1:0] DQ_IN,
   output logic [asrc_pkg::DATA_W-1:0]      DQ_OUT,
   output logic                             DQ_OE_N
);
   asrc_pkg::asrc_state_type   state_r;
   asrc_pkg::asrc_state_type   state_nxt;
   asrc_pkg::asrc_req_type     req_r;
   logic [asrc_pkg::DATA_W-1:0] dq_s1_r;
   logic [asrc_pkg::DATA_W-1:0] dq_s2_r;
   logic [asrc_pkg::DATA_W-1:0] dq_s3_r;
   logic [21:0]                power_cnt_r;
   logic                       t_load;
   logic [asrc_pkg::CNT_W-1:0] t_value;
   logic                       t_done;

   asrc_timer u_timer (
      .clk   (REF_CLK),
      .rst_n (RSTN),
      .load  (t_load),
      .value (t_value),
      .done  (t_done)
   );

   // ------------------------------------------------------------
   // Power-up wait
   // ------------------------------------------------------------
   // The wait would fit the 12-bit phase timer, but it has its own 22-bit count.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         power_cnt_r <= 22'(asrc_pkg::POWER_CYC);
      end else if (power_cnt_r != '0) begin
         power_cnt_r <= power_cnt_r - 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      t_load = 1'b0;
      t_value = '0;
      unique case (state_r)
         asrc_pkg::ST_POWER: begin
            if (power_cnt_r == '0) begin
               state_nxt = asrc_pkg::ST_IDLE;
            end
         end
         asrc_pkg::ST_IDLE: begin
            if (RETAIN) begin
               state_nxt = asrc_pkg::ST_RETAIN;
            end else if (REQ_VALID) begin
               // Address and data settle one cycle before strobes fall.
               state_nxt = asrc_pkg::ST_SETUP;
            end
         end
         asrc_pkg::ST_SETUP: begin
            t_load = 1'b1;
            if (req_r.write) begin
               state_nxt = asrc_pkg::ST_WRITE;
               t_value = asrc_pkg::CNT_W'(asrc_pkg::WR_CYC
                         + asrc_pkg::PWE_CYC - 1);
            end else begin
               state_nxt = asrc_pkg::ST_READ;
               t_value = asrc_pkg::CNT_W'(asrc_pkg::RD_CYC + 2);
            end
         end
         asrc_pkg::ST_WRITE, asrc_pkg::ST_READ: begin
            if (t_done) begin
               t_load = 1'b1;
               t_value = asrc_pkg::CNT_W'(asrc_pkg::GAP_CYC - 1);
               state_nxt = asrc_pkg::ST_GAP;
            end
         end
         asrc_pkg::ST_GAP: begin
            if (t_done) begin
               state_nxt = asrc_pkg::ST_IDLE;
            end
         end
         asrc_pkg::ST_RETAIN: begin
            if (!RETAIN) begin
               state_nxt = asrc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_r <= asrc_pkg::ST_POWER;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign REQ_READY = (state_r == asrc_pkg::ST_IDLE) && !RETAIN;
   assign RETAINED = (state_r == asrc_pkg::ST_RETAIN);

   // ------------------------------------------------------------
   // Request capture
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         req_r <= '0;
      end else if (REQ_VALID && REQ_READY) begin
         req_r <= REQ;
      end
   end

   // ------------------------------------------------------------
   // Pin drive
   // ------------------------------------------------------------
   // All pins come from flip-flops so no glitch can open a write.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         MEM <= '{sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  low_byte_lane_enable_n: 1'b1,
                  high_byte_lane_enable_n: 1'b1, addr: '0};
         DQ_OUT <= '0;
         DQ_OE_N <= 1'b1;
      end else begin
         // Address and data go out at the take, a cycle before strobes.
         if (REQ_VALID && REQ_READY) begin
            MEM.addr <= REQ.addr;
            DQ_OUT <= REQ.wdata;
         end
         // Select and strobe fall and rise together at the write bounds.
         MEM.sel_n <= !(state_nxt == asrc_pkg::ST_WRITE
                     || state_nxt == asrc_pkg::ST_READ);
         MEM.we_n <= !(state_nxt == asrc_pkg::ST_WRITE);
         MEM.oe_n <= !(state_nxt == asrc_pkg::ST_READ);
         MEM.low_byte_lane_enable_n <= !((state_nxt == asrc_pkg::ST_WRITE
            || state_nxt == asrc_pkg::ST_READ) && !req_r.lane_n[0]);
         MEM.high_byte_lane_enable_n <= !((state_nxt == asrc_pkg::ST_WRITE
            || state_nxt == asrc_pkg::ST_READ) && !req_r.lane_n[1]);
         // Data stays driven through the gap, covering hold after the end.
         DQ_OE_N <= !(state_nxt == asrc_pkg::ST_WRITE
                   || (state_nxt == asrc_pkg::ST_GAP && req_r.write)
                   || (state_nxt == asrc_pkg::ST_SETUP && REQ.write
                       && state_r == asrc_pkg::ST_IDLE));
      end
   end

   // ------------------------------------------------------------
   // Read capture
   // ------------------------------------------------------------
   // Three flops on the pins; sampling at the read's last cycle is
   // far beyond every access time, so the agreeing flops are read.
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
         dq_s3_r <= '0;
      end else begin
         dq_s1_r <= DQ_IN;
         dq_s2_r <= dq_s1_r;
         dq_s3_r <= dq_s2_r;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         RD_VALID <= 1'b0;
         RD_DATA <= '0;
      end else begin
         RD_VALID <= (state_r == asrc_pkg::ST_READ) && t_done
                     && (dq_s2_r == dq_s3_r);
         if ((state_r == asrc_pkg::ST_READ) && t_done) begin
            // Disabled lanes float, so they read back as zero.
            RD_DATA <= {req_r.lane_n[1] ? 8'h00 : dq_s3_r[15:8],
                        req_r.lane_n[0] ? 8'h00 : dq_s3_r[7:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_we_needs_sel: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      !MEM.we_n |-> !MEM.sel_n)
      else $error("strobe low while deselected");
   a_read_we_high: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      !MEM.oe_n |-> MEM.we_n)
      else $error("strobe low in read");
   a_data_hold: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      $rose(MEM.we_n) |-> !DQ_OE_N && $stable(DQ_OUT))
      else $error("data not held at write end");
   a_addr_stable: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      !MEM.sel_n && !$rose(MEM.sel_n) |=> $stable(MEM.addr) || MEM.sel_n)
      else $error("address moved in access");
   a_addr_lead: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      $fell(MEM.sel_n) |-> $stable(MEM.addr))
      else $error("address changed at start");
   // Two cycles is the write phase that the least times give at this clock.
   a_write_len: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      $fell(MEM.we_n) |-> !MEM.we_n [*2])
      else $error("write too short");
   a_lane_write: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      !MEM.we_n |-> {MEM.high_byte_lane_enable_n,
                     MEM.low_byte_lane_enable_n} == req_r.lane_n)
      else $error("lane enable off in write");
   a_power_wait: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      power_cnt_r != '0 |-> MEM.sel_n)
      else $error("access before power");
   a_retain_desel: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      RETAINED |-> MEM.sel_n && DQ_OE_N)
      else $error("selected in retention");
   a_gap_desel: assert property (
      @(posedge REF_CLK) disable iff (!RSTN)
      $rose(MEM.sel_n) |=> MEM.sel_n)
      else $error("no gap between cycles");
endmodule : asrc_ctrl

// ==== dv/asrc_sram_model.sv ====
/*
 Behavioural model of the 256K x 16 static RAM on the controller's pins.
 Assumes the controller's split data bus; the model resolves the wire.
*/
module asrc_sram_model (
   // Pins from the controller
   input  wire asrc_pkg::asrc_pins_type pins,
   input  wire logic [15:0]             dq_out,
   input  wire logic                    dq_oe_n,
   // Resolved data wire
   output logic [15:0]                  dq_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] arr [0:262143];
   logic [15:0] wd;
   logic [17:0] wa;
   logic [1:0]  wl;
   logic        wr_on = 1'h0;
   logic        lo_on;
   logic        hi_on;
   // ------------------------------------------------------------
   // Write
   // ------------------------------------------------------------
   always @(pins or dq_out) begin
      if (!pins.sel_n && !pins.we_n) begin
         wr_on = 1'h1;
         wa = pins.addr;
         wd = dq_out;
         wl = {pins.high_byte_lane_enable_n, pins.low_byte_lane_enable_n};
      end else if (wr_on) begin
         wr_on = 1'h0;
         if (!wl[0]) arr[wa][7:0] = wd[7:0];
         if (!wl[1]) arr[wa][15:8] = wd[15:8];
      end
   end
   // ------------------------------------------------------------
   // Read
   // ------------------------------------------------------------
   // A released lane shows the inverse of its last level, so a controller
   // that samples an undriven lane cannot pass by luck.
   initial dq_in = 16'h5A5A;
   always @(pins or dq_out or dq_oe_n or wr_on) begin
      lo_on = !pins.sel_n && !pins.oe_n && pins.we_n
              && !pins.low_byte_lane_enable_n;
      hi_on = !pins.sel_n && !pins.oe_n && pins.we_n
              && !pins.high_byte_lane_enable_n;
      if (!dq_oe_n) begin
         dq_in <= dq_out;
      end else begin
         dq_in[7:0] <= #4 lo_on ? arr[pins.addr][7:0]
                                : ~dq_in[7:0];
         dq_in[15:8] <= #4 hi_on ? arr[pins.addr][15:8]
                                 : ~dq_in[15:8];
      end
   end
endmodule : asrc_sram_model

// ==== dv/tb.sv ====
/*
 Self-checking bench for the static RAM host controller.
 Assumes the design package and the RAM model are compiled first.
*/
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic                    ref_clk = 1'h0;
   logic                    rstn = 1'h0;
   logic                    req_valid = 1'h0;
   logic                    retain = 1'h0;
   asrc_pkg::asrc_req_type  req = '0;
   asrc_pkg::asrc_pins_type mem;
   logic                    req_ready, rd_valid, retained, dq_oe_n;
   logic [15:0]             rd_data, dq_in, dq_out, q;
   logic [17:0]             w_addr, p_addr;
   logic                    in_wr = 1'h0;
   int                      num_errors = 0;
   int                      tests_run = 0;
   int                      n;
   int                      gap_n = 0;
   asrc_ctrl dut (.REF_CLK(ref_clk), .RSTN(rstn), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ(req), .RD_VALID(rd_valid),
      .RD_DATA(rd_data), .RETAIN(retain), .RETAINED(retained), .MEM(mem),
      .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n));
   asrc_sram_model ram (.pins(mem), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
      .dq_in(dq_in));
   initial forever #25 ref_clk = ~ref_clk;
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // Ready is sampled on the falling edge, where it has settled.
   task automatic access(logic w, logic [1:0] ln, logic [17:0] a,
                         logic [15:0] d, output logic [15:0] rd);
      @(posedge ref_clk);
      req_valid <= 1'h1;
      req <= '{write: w, lane_n: ln, addr: a, wdata: d};
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (req_ready !== 1'h1 && n < 100);
      @(posedge ref_clk);
      req_valid <= 1'h0;
      rd = 16'h0000;
      if (!w) begin
         n = 0;
         do begin @(negedge ref_clk); n++; end
         while (rd_valid !== 1'h1 && n < 40);
         chk("rd_valid", 18'h1, rd_valid);
         rd = rd_data;
      end
   endtask : access
   // ------------------------------------------------------------
   // Pin monitor
   // ------------------------------------------------------------
   always @(negedge ref_clk) begin
      if (rstn) begin
         if (!mem.oe_n && !mem.sel_n) chk("we_n in read", 18'h1, mem.we_n);
         if (!mem.we_n) begin
            if (!in_wr) chk("addr lead", p_addr, mem.addr);
            if (!in_wr) w_addr = mem.addr;
            chk("sel_n in write", 18'h0, mem.sel_n);
            chk("write addr", w_addr, mem.addr);
            chk("write dq_oe_n", 18'h0, dq_oe_n);
            chk("lane", 18'h0, mem.low_byte_lane_enable_n
                & mem.high_byte_lane_enable_n);
         end else if (in_wr) chk("data hold", 18'h0, dq_oe_n);
         if (mem.sel_n) begin
            gap_n++;
         end else if (gap_n != 0) begin
            chk("gap", 18'h1, 18'(gap_n >= asrc_pkg::GAP_CYC));
            gap_n = 0;
         end
         in_wr = !mem.we_n;
         p_addr = mem.addr;
      end
   end
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_basic;
      access(1'h1, 2'h0, 18'h00010, 16'hA55A, q);
      access(1'h1, 2'h0, 18'h3FFFF, 16'h1234, q);
      access(1'h0, 2'h0, 18'h00010, 16'h0000, q);
      chk("read low addr", 18'hA55A, q);
      access(1'h0, 2'h0, 18'h3FFFF, 16'h0000, q);
      chk("read top addr", 18'h1234, q);
      $display("test basic done");
   endtask : t_basic
   task automatic t_lanes;
      access(1'h1, 2'h0, 18'h00005, 16'hFFFF, q);
      access(1'h1, 2'h2, 18'h00005, 16'h0011, q);
      access(1'h0, 2'h0, 18'h00005, 16'h0000, q);
      chk("low lane write", 18'hFF11, q);
      access(1'h1, 2'h1, 18'h00005, 16'h2200, q);
      access(1'h0, 2'h2, 18'h00005, 16'h0000, q);
      chk("low lane read", 18'h0011, q);
      access(1'h0, 2'h1, 18'h00005, 16'h0000, q);
      chk("high lane read", 18'h2200, q);
      $display("test lanes done");
   endtask : t_lanes
   // Back-to-back requests keep the spacing logic busy.
   task automatic t_burst;
      for (int i = 0; i < 4; i++) begin
         access(1'h1, 2'h0, 18'(i + 32), 16'(16'hC000 + i), q);
      end
      for (int i = 0; i < 4; i++) begin
         access(1'h0, 2'h0, 18'(i + 32), 16'h0000, q);
         chk("burst read", 18'(16'hC000 + i), q);
      end
      $display("test burst done");
   endtask : t_burst
   task automatic t_retain;
      @(posedge ref_clk);
      retain <= 1'h1;
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (retained !== 1'h1 && n < 50);
      chk("retained", 18'h1, retained);
      repeat (8) begin
         @(negedge ref_clk);
         chk("retain pins", 18'h2, {mem.sel_n, req_ready});
      end
      @(posedge ref_clk);
      retain <= 1'h0;
      access(1'h0, 2'h0, 18'h00010, 16'h0000, q);
      chk("after retain", 18'hA55A, q);
      $display("test retain done");
   endtask : t_retain
   initial begin
      repeat (16) @(posedge ref_clk);
      chk("reset pins", 18'h1F, {mem.sel_n, mem.oe_n, mem.we_n, dq_oe_n,
          ~req_ready});
      rstn <= 1'h1;
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while (req_ready !== 1'h1 && n < 3000);
      chk("power wait", 18'h1, 18'(n >= 2000));
      $display("test power done");
      t_basic();
      t_lanes();
      t_burst();
      t_retain();
      conclude();
   end
   // The run needs about 2150 cycles; a limit of 25000 cycles marks a hang.
   initial begin
      #(25000 * 50);
      num_errors++;
      conclude();
   end
endmodule : tb
